/* core/ifb_flag_bank.sv */
`timescale 1ns/10ps
module ifb_flag_bank (
   input wire logic clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ifb_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Source request pulses, register 0
   input wire logic adc_done_req,
   input wire logic serial1_tx_req,
   input wire logic serial1_rx_req,
   input wire logic spi_port1_event_req,
   input wire logic spi_port1_fault_req,
   input wire logic timer_three_req,
   input wire logic timer_two_req,
   input wire logic compare_two_req,
   input wire logic capture_two_req,
   input wire logic timer_one_req,
   input wire logic compare_one_req,
   input wire logic capture_one_req,
   input wire logic ext_irq_zero_req,
   // Source request pulses, register 1
   input wire logic serial2_tx_req,
   input wire logic serial2_rx_req,
   input wire logic ext_irq_two_req,
   input wire logic timer_five_req,
   input wire logic timer_four_req,
   input wire logic compare_four_req,
   input wire logic compare_three_req,
   input wire logic ext_irq_one_req,
   input wire logic pin_change_req,
   input wire logic comparator_req,
   input wire logic i2c_port1_master_req,
   input wire logic i2c_port1_slave_req,
   // Source request pulses, register 2
   input wire logic parallel_port_req,
   input wire logic compare_five_req,
   input wire logic capture_five_req,
   input wire logic capture_four_req,
   input wire logic capture_three_req,
   input wire logic spi_port2_event_req,
   input wire logic spi_port2_fault_req,
   // Source request pulses, register 3
   input wire logic calendar_req,
   input wire logic i2c_port2_master_req,
   input wire logic i2c_port2_slave_req,
   // Source request pulses, register 4
   input wire logic charge_timing_req,
   input wire logic low_voltage_req,
   input wire logic crc_engine_req,
   input wire logic serial2_error_req,
   input wire logic serial1_error_req,
   // Toward the priority logic
   output ifb_pkg::ifb_bank_t pending,
   output ifb_pkg::ifb_bank_t fwd_req,
   output logic irq
);

   ifb_pkg::ifb_apb_req_s apb;
   ifb_pkg::ifb_bank_t src_req;
   ifb_pkg::ifb_bank_t pend_r;
   ifb_pkg::ifb_bank_t pend_nxt;
   ifb_pkg::ifb_bank_t en_r;
   ifb_pkg::ifb_bank_t fwd_r;
   ifb_pkg::ifb_evt_t evt_stat_r;
   ifb_pkg::ifb_evt_t evt_stat_nxt;
   ifb_pkg::ifb_evt_t evt_mask_r;
   ifb_pkg::ifb_evt_t evt_mask_nxt;
   ifb_pkg::ifb_evt_t new_flag;
   ifb_pkg::ifb_evt_t pend_wr;
   ifb_pkg::ifb_evt_t en_wr;
   logic [31:0] prdata_r;
   logic [31:0] rd_word;
   logic addr_hit;
   logic setup_ph;
   logic access_ph;
   logic wr_xfer;
   logic rd_xfer;
   logic stat_hit;
   logic mask_hit;

   ////////////////////////////////////////////////////////////////////////
   // Request map

   // Register 0 sources in vector order, bits 15..14 and 4 left unused
   always_comb begin
      // Unwired positions stay zero so no request can ever reach them
      src_req = '0;
      src_req[0][ifb_pkg::ADC_DONE_PENDING] = adc_done_req;
      src_req[0][ifb_pkg::SERIAL1_TX_PENDING] = serial1_tx_req;
      src_req[0][ifb_pkg::SERIAL1_RX_PENDING] = serial1_rx_req;
      src_req[0][ifb_pkg::SPI_PORT1_EVENT_PENDING] =
         spi_port1_event_req;
      src_req[0][ifb_pkg::SPI_PORT1_FAULT_PENDING] =
         spi_port1_fault_req;
      src_req[0][ifb_pkg::TIMER_THREE_PENDING] = timer_three_req;
      src_req[0][ifb_pkg::TIMER_TWO_PENDING] = timer_two_req;
      src_req[0][ifb_pkg::COMPARE_TWO_PENDING] = compare_two_req;
      src_req[0][ifb_pkg::CAPTURE_TWO_PENDING] = capture_two_req;
      src_req[0][ifb_pkg::TIMER_ONE_PENDING] = timer_one_req;
      src_req[0][ifb_pkg::COMPARE_ONE_PENDING] = compare_one_req;
      src_req[0][ifb_pkg::CAPTURE_ONE_PENDING] = capture_one_req;
      // Vector zero lands on bit 0 of the first register
      src_req[0][ifb_pkg::EXT_IRQ_ZERO_PENDING] =
         ext_irq_zero_req;
      // Register 1, bits 8..5 left unused
      src_req[1][ifb_pkg::SERIAL2_TX_PENDING] = serial2_tx_req;
      src_req[1][ifb_pkg::SERIAL2_RX_PENDING] = serial2_rx_req;
      src_req[1][ifb_pkg::EXT_IRQ_TWO_PENDING] = ext_irq_two_req;
      src_req[1][ifb_pkg::TIMER_FIVE_PENDING] = timer_five_req;
      src_req[1][ifb_pkg::TIMER_FOUR_PENDING] = timer_four_req;
      src_req[1][ifb_pkg::COMPARE_FOUR_PENDING] = compare_four_req;
      src_req[1][ifb_pkg::COMPARE_THREE_PENDING] =
         compare_three_req;
      src_req[1][ifb_pkg::EXT_IRQ_ONE_PENDING] = ext_irq_one_req;
      src_req[1][ifb_pkg::PIN_CHANGE_PENDING] = pin_change_req;
      src_req[1][ifb_pkg::COMPARATOR_PENDING] = comparator_req;
      src_req[1][ifb_pkg::I2C_PORT1_MASTER_PENDING] =
         i2c_port1_master_req;
      src_req[1][ifb_pkg::I2C_PORT1_SLAVE_PENDING] =
         i2c_port1_slave_req;
      // Register 2
      src_req[2][ifb_pkg::PARALLEL_PORT_PENDING] =
         parallel_port_req;
      src_req[2][ifb_pkg::COMPARE_FIVE_PENDING] = compare_five_req;
      src_req[2][ifb_pkg::CAPTURE_FIVE_PENDING] = capture_five_req;
      src_req[2][ifb_pkg::CAPTURE_FOUR_PENDING] = capture_four_req;
      src_req[2][ifb_pkg::CAPTURE_THREE_PENDING] =
         capture_three_req;
      src_req[2][ifb_pkg::SPI_PORT2_EVENT_PENDING] =
         spi_port2_event_req;
      src_req[2][ifb_pkg::SPI_PORT2_FAULT_PENDING] =
         spi_port2_fault_req;
      // Register 3
      src_req[3][ifb_pkg::CALENDAR_PENDING] = calendar_req;
      src_req[3][ifb_pkg::I2C_PORT2_MASTER_PENDING] =
         i2c_port2_master_req;
      src_req[3][ifb_pkg::I2C_PORT2_SLAVE_PENDING] =
         i2c_port2_slave_req;
      // Register 4
      src_req[4][ifb_pkg::CHARGE_TIMING_PENDING] =
         charge_timing_req;
      src_req[4][ifb_pkg::LOW_VOLTAGE_PENDING] = low_voltage_req;
      src_req[4][ifb_pkg::CRC_ENGINE_PENDING] = crc_engine_req;
      src_req[4][ifb_pkg::SERIAL2_ERROR_PENDING] =
         serial2_error_req;
      src_req[4][ifb_pkg::SERIAL1_ERROR_PENDING] =
         serial1_error_req;
   end

   ////////////////////////////////////////////////////////////////////////
   // APB phases

   // Gather the bus request into one bundle
   assign apb = '{sel: psel, enable: penable, write: pwrite,
      addr: paddr, wdata: pwdata};

   // Setup loads read data, access completes with zero wait
   assign setup_ph = apb.sel & ~apb.enable;
   assign access_ph = apb.sel & apb.enable;
   assign wr_xfer = access_ph & apb.write & addr_hit;
   assign rd_xfer = access_ph & ~apb.write & addr_hit;
   assign pready = access_ph;
   assign pslverr = access_ph & ~addr_hit; // Unmapped address
   assign prdata = prdata_r;

   // Single-word registers that sit outside the two banks
   assign stat_hit = apb.addr == ifb_pkg::EVT_STAT_OFS;
   assign mask_hit = apb.addr == ifb_pkg::EVT_MASK_OFS;

   ////////////////////////////////////////////////////////////////////////
   // Address decode and read mux

   // Decode one word per register and build the read word
   always_comb begin
      addr_hit = 1'b0;
      rd_word = ifb_pkg::RDATA_RST;
      pend_wr = '0;
      en_wr = '0;
      for (int i = 0; i < ifb_pkg::NUM_REGS; i++) begin
         if (apb.addr == ifb_pkg::PEND_BASE +
               ifb_pkg::WORD_STEP * 8'(i)) begin
            addr_hit = 1'b1;
            pend_wr[i] = 1'b1;
            // Unused positions always hold zero
            rd_word = {16'h0000, pend_r[i]};
         end
         if (apb.addr == ifb_pkg::EN_BASE +
               ifb_pkg::WORD_STEP * 8'(i)) begin
            addr_hit = 1'b1;
            en_wr[i] = 1'b1;
            rd_word = {16'h0000, en_r[i]};
         end
      end
      // Event status and mask hold one bit per flag register
      if (stat_hit) begin
         addr_hit = 1'b1;
         rd_word = {27'h000_0000, evt_stat_r};
      end
      if (mask_hit) begin
         addr_hit = 1'b1;
         rd_word = {27'h000_0000, evt_mask_r};
      end
   end

   // Read data captured in the setup cycle, held through access; a status
   // read thus misses an event raised in its setup cycle, which its access cycle clears
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata_r <= ifb_pkg::RDATA_RST;
      end else if (setup_ph) begin
         prdata_r <= rd_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pending flags

   // Per register: software write, then hardware requests on top
   // A source held high keeps its flag set through any clear, so software
   // must quiet the source before clearing its flag
   for (genvar g = 0; g < ifb_pkg::NUM_REGS; g++) begin : g_flag
      always_comb begin
         pend_nxt[g] = pend_r[g];
         // Writes land only on implemented bits
         if (wr_xfer && pend_wr[g]) begin
            pend_nxt[g] = pwdata[15:0] & ifb_pkg::IMPL_MASK[g];
         end
         // Requests OR in after the write, so a set beats a clear
         pend_nxt[g] = pend_nxt[g] |
            (src_req[g] & ifb_pkg::IMPL_MASK[g]);
         // A request raising a flag from zero is an event for this register
         new_flag[g] = |(src_req[g] & ifb_pkg::IMPL_MASK[g] & ~pend_r[g]);
      end
   end

   // Flag storage, cleared on reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pend_r <= {ifb_pkg::NUM_REGS{ifb_pkg::PEND_RST}};
      end else begin
         pend_r <= pend_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Source enables and forwarding

   // Enable bits share the flag layout
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         en_r <= {ifb_pkg::NUM_REGS{ifb_pkg::EN_RST}};
      end else begin
         for (int i = 0; i < ifb_pkg::NUM_REGS; i++) begin
            if (wr_xfer && en_wr[i]) begin
               en_r[i] <= pwdata[15:0] & ifb_pkg::IMPL_MASK[i];
            end
         end
      end
   end

   // Only enabled flags go on to the priority logic
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fwd_r <= {ifb_pkg::NUM_REGS{ifb_pkg::PEND_RST}};
      end else begin
         for (int i = 0; i < ifb_pkg::NUM_REGS; i++) begin
            fwd_r[i] <= pend_nxt[i] & en_r[i];
         end
      end
   end

   // The flag store drives the pending output directly
   assign pending = pend_r;
   assign fwd_req = fwd_r;

   ////////////////////////////////////////////////////////////////////////
   // Event status, mask and interrupt line

   // Sticky per-register events; a read clears, a new event wins
   always_comb begin
      evt_stat_nxt = evt_stat_r;
      // Clear only on a read that completes at the status word
      if (rd_xfer && stat_hit) begin
         evt_stat_nxt = ifb_pkg::EVT_RST;
      end
      evt_stat_nxt = evt_stat_nxt | new_flag;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         evt_stat_r <= ifb_pkg::EVT_RST;
      end else begin
         evt_stat_r <= evt_stat_nxt;
      end
   end

   // Mask next value, so the line follows a mask write in the same cycle
   always_comb begin
      evt_mask_nxt = evt_mask_r;
      if (wr_xfer && mask_hit) begin
         evt_mask_nxt = pwdata[ifb_pkg::NUM_REGS-1:0];
      end
   end

   // Mask register, one bit per flag register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         evt_mask_r <= ifb_pkg::EVT_RST;
      end else begin
         evt_mask_r <= evt_mask_nxt;
      end
   end

   // Level output while any unmasked event is held; built from next
   // values so it moves in the same cycle as status and mask
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(evt_stat_nxt & evt_mask_nxt);
      end
   end

endmodule

/* core/ifb_pkg.sv */
package ifb_pkg;

   // Bank shape
   localparam int NUM_REGS = 5;
   localparam int REG_W = 16;
   localparam int ADDR_W = 8;

   typedef logic [REG_W-1:0] ifb_word_t;
   typedef ifb_word_t [NUM_REGS-1:0] ifb_bank_t;
   typedef logic [NUM_REGS-1:0] ifb_evt_t;

   // One APB request as seen by the slave
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
   } ifb_apb_req_s;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] PEND_BASE = 8'h00;
   localparam logic [ADDR_W-1:0] EN_BASE = 8'h20;
   localparam logic [ADDR_W-1:0] EVT_STAT_OFS = 8'h40;
   localparam logic [ADDR_W-1:0] EVT_MASK_OFS = 8'h44;
   localparam logic [ADDR_W-1:0] WORD_STEP = 8'h04;

   // Implemented bits per flag register, register 0 first
   localparam ifb_word_t IMPL_MASK_0 = 16'h3fef;
   localparam ifb_word_t IMPL_MASK_1 = 16'hfe1f;
   localparam ifb_word_t IMPL_MASK_2 = 16'h22e3;
   localparam ifb_word_t IMPL_MASK_3 = 16'h4006;
   localparam ifb_word_t IMPL_MASK_4 = 16'h210e;
   localparam ifb_bank_t IMPL_MASK = {IMPL_MASK_4, IMPL_MASK_3,
      IMPL_MASK_2, IMPL_MASK_1, IMPL_MASK_0};

   // Reset values
   localparam ifb_word_t PEND_RST = 16'h0000;
   localparam ifb_word_t EN_RST = 16'h0000;
   localparam ifb_evt_t EVT_RST = 5'h00;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

   // Flag positions, register 0
   localparam int ADC_DONE_PENDING = 13;
   localparam int SERIAL1_TX_PENDING = 12;
   localparam int SERIAL1_RX_PENDING = 11;
   localparam int SPI_PORT1_EVENT_PENDING = 10;
   localparam int SPI_PORT1_FAULT_PENDING = 9;
   localparam int TIMER_THREE_PENDING = 8;
   localparam int TIMER_TWO_PENDING = 7;
   localparam int COMPARE_TWO_PENDING = 6;
   localparam int CAPTURE_TWO_PENDING = 5;
   localparam int TIMER_ONE_PENDING = 3;
   localparam int COMPARE_ONE_PENDING = 2;
   localparam int CAPTURE_ONE_PENDING = 1;
   localparam int EXT_IRQ_ZERO_PENDING = 0;
   // Flag positions, register 1
   localparam int SERIAL2_TX_PENDING = 15;
   localparam int SERIAL2_RX_PENDING = 14;
   localparam int EXT_IRQ_TWO_PENDING = 13;
   localparam int TIMER_FIVE_PENDING = 12;
   localparam int TIMER_FOUR_PENDING = 11;
   localparam int COMPARE_FOUR_PENDING = 10;
   localparam int COMPARE_THREE_PENDING = 9;
   localparam int EXT_IRQ_ONE_PENDING = 4;
   localparam int PIN_CHANGE_PENDING = 3;
   localparam int COMPARATOR_PENDING = 2;
   localparam int I2C_PORT1_MASTER_PENDING = 1;
   localparam int I2C_PORT1_SLAVE_PENDING = 0;
   // Flag positions, register 2
   localparam int PARALLEL_PORT_PENDING = 13;
   localparam int COMPARE_FIVE_PENDING = 9;
   localparam int CAPTURE_FIVE_PENDING = 7;
   localparam int CAPTURE_FOUR_PENDING = 6;
   localparam int CAPTURE_THREE_PENDING = 5;
   localparam int SPI_PORT2_EVENT_PENDING = 1;
   localparam int SPI_PORT2_FAULT_PENDING = 0;
   // Flag positions, register 3
   localparam int CALENDAR_PENDING = 14;
   localparam int I2C_PORT2_MASTER_PENDING = 2;
   localparam int I2C_PORT2_SLAVE_PENDING = 1;
   // Flag positions, register 4
   localparam int CHARGE_TIMING_PENDING = 13;
   localparam int LOW_VOLTAGE_PENDING = 8;
   localparam int CRC_ENGINE_PENDING = 3;
   localparam int SERIAL2_ERROR_PENDING = 2;
   localparam int SERIAL1_ERROR_PENDING = 1;

endpackage

/* tb/ifb_flag_bank_sva.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
// Port-level checker for the flag bank
module ifb_flag_bank_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ifb_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic adc_done_req,
   input wire ifb_pkg::ifb_bank_t pending,
   input wire ifb_pkg::ifb_bank_t fwd_req,
   input wire logic irq
);
   localparam ifb_pkg::ifb_bank_t IMPL = {16'h210e, 16'h4006, 16'h22e3,
      16'hfe1f, 16'h3fef};
   logic wr0;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Software write to flag register zero
   assign wr0 = psel && penable && pwrite && paddr == 8'h00;
   a_zero_wait: assert property (pready == (psel && penable))
      else $error("pready not tied to access phase");
   a_bad_addr: assert property (psel && penable && paddr == 8'h80 |->
      pslverr && (pwrite || prdata == 32'h0000_0000))
      else $error("unmapped access not refused");
   a_unimpl_zero: assert property ((pending & ~IMPL) == '0)
      else $error("unimplemented flag bit set");
   a_req_sets: assert property (adc_done_req |=> pending[0][13])
      else $error("request did not set flag");
   a_no_spurious: assert property (
      !pending[0][13] && !adc_done_req && !(wr0 && pwdata[13])
      |=> !pending[0][13])
      else $error("flag set without cause");
   a_flag_holds: assert property (
      pending[0][13] && !(wr0 && !pwdata[13]) |=> pending[0][13])
      else $error("flag dropped without clear");
   a_sw_clear: assert property (
      wr0 && !pwdata[13] && !adc_done_req |=> !pending[0][13])
      else $error("software clear ignored");
   a_fwd_gated: assert property ((fwd_req & ~pending) == '0)
      else $error("forwarded request without flag");
   a_reset_clear: assert property (
      $rose(rst_n) |-> pending == '0 && !irq)
      else $error("state not cleared by reset");
   c_race: cover property (wr0 && !pwdata[13] && adc_done_req);
   c_refused: cover property (pslverr);
   c_irq: cover property ($rose(irq));
endmodule
bind ifb_flag_bank ifb_flag_bank_sva u_sva (.clk(clk), .rst_n(rst_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .adc_done_req(adc_done_req), .pending(pending), .fwd_req(fwd_req),
   .irq(irq));

/* tb/ifb_src_model.sv */
`timescale 1ns/10ps
// Peripheral sources: raise requests one clock after being told to
module ifb_src_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire ifb_pkg::ifb_bank_t go,
   output ifb_pkg::ifb_bank_t rq
);
   // Registered request lines, quiet in reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rq <= '0;
      end else begin
         rq <= go;
      end
   end
endmodule

/* tb/ifb_flag_bank_bench.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
   n_mismatch++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module ifb_flag_bank_bench;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, rerr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   ifb_pkg::ifb_bank_t go, rq, pending, fwd_req, v, e;
   int n_mismatch = 0;
   int compares = 0;
   logic [15:0] msk [5] = '{16'h3fef, 16'hfe1f, 16'h22e3, 16'h4006,
      16'h210e};
   ifb_src_model SRC (.clk(clk), .rst_n(rst_n), .go(go), .rq(rq));
   ifb_flag_bank DUT (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .adc_done_req(rq[0][13]), .serial1_tx_req(rq[0][12]),
      .serial1_rx_req(rq[0][11]), .spi_port1_event_req(rq[0][10]),
      .spi_port1_fault_req(rq[0][9]), .timer_three_req(rq[0][8]),
      .timer_two_req(rq[0][7]), .compare_two_req(rq[0][6]),
      .capture_two_req(rq[0][5]), .timer_one_req(rq[0][3]),
      .compare_one_req(rq[0][2]), .capture_one_req(rq[0][1]),
      .ext_irq_zero_req(rq[0][0]), .serial2_tx_req(rq[1][15]),
      .serial2_rx_req(rq[1][14]), .ext_irq_two_req(rq[1][13]),
      .timer_five_req(rq[1][12]), .timer_four_req(rq[1][11]),
      .compare_four_req(rq[1][10]), .compare_three_req(rq[1][9]),
      .ext_irq_one_req(rq[1][4]), .pin_change_req(rq[1][3]),
      .comparator_req(rq[1][2]), .i2c_port1_master_req(rq[1][1]),
      .i2c_port1_slave_req(rq[1][0]), .parallel_port_req(rq[2][13]),
      .compare_five_req(rq[2][9]), .capture_five_req(rq[2][7]),
      .capture_four_req(rq[2][6]), .capture_three_req(rq[2][5]),
      .spi_port2_event_req(rq[2][1]), .spi_port2_fault_req(rq[2][0]),
      .calendar_req(rq[3][14]), .i2c_port2_master_req(rq[3][2]),
      .i2c_port2_slave_req(rq[3][1]), .charge_timing_req(rq[4][13]),
      .low_voltage_req(rq[4][8]), .crc_engine_req(rq[4][3]),
      .serial2_error_req(rq[4][2]), .serial1_error_req(rq[4][1]),
      .pending(pending), .fwd_req(fwd_req), .irq(irq));
   ////////////////////////////////////////////////////////////////////
   // Verdict and bus tasks
   task give_verdict;
      if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         n_mismatch++;
         give_verdict();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task pulse(input ifb_pkg::ifb_bank_t p);
      @(posedge clk);
      go <= p;
      @(posedge clk);
      go <= '0;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////
   // Scenarios
   task s_reset;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         `CHK("pend rst", 32'h0000_0000, rdat)
      end
      @(negedge clk);
      `CHK("irq rst", 1'b0, irq)
   endtask
   task s_rw;
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, 8'(i * 4), 32'hffff_ffff);
         apb(1'b0, 8'(i * 4), 32'h0);
         `CHK("pend rw", {16'h0000, msk[i]}, rdat)
         apb(1'b1, 8'(i * 4), 32'h0);
         apb(1'b0, 8'(i * 4), 32'h0);
         `CHK("pend clr", 32'h0000_0000, rdat)
         `CHK("pend err", 1'b0, rerr)
      end
   endtask
   task s_src;
      for (int i = 0; i < 5; i++) begin
         for (int b = 0; b < 16; b++) begin
            v = '0;
            v[i][b] = 1'b1;
            pulse(v);
            e = '0;
            e[i] = v[i] & msk[i];
            `CHK("source map", e, pending)
            apb(1'b0, 8'(i * 4), 32'h0);
            `CHK("src rd", {16'h0000, e[i]}, rdat)
            `CHK("fwd off", '0, fwd_req)
            apb(1'b1, 8'(i * 4), 32'h0);
         end
      end
   endtask
   task s_irq;
      @(negedge clk);
      `CHK("irq masked", 1'b0, irq)
      apb(1'b0, 8'h40, 32'h0);
      `CHK("status all", 32'h0000_001f, rdat)
      apb(1'b1, 8'h44, 32'h1);
      v = '0;
      v[0][0] = 1'b1;
      pulse(v);
      `CHK("irq on", 1'b1, irq)
      apb(1'b0, 8'h40, 32'h0);
      `CHK("status one", 32'h0000_0001, rdat)
      @(posedge clk);
      @(negedge clk);
      `CHK("irq cleared", 1'b0, irq)
      v = '0;
      v[1][0] = 1'b1;
      pulse(v);
      `CHK("irq blocked", 1'b0, irq)
      apb(1'b0, 8'h40, 32'h0);
      `CHK("status two", 32'h0000_0002, rdat)
   endtask
   task s_enable;
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h20, 32'h0000_0008);
      v = '0;
      v[0][3] = 1'b1;
      v[0][2] = 1'b1;
      pulse(v);
      `CHK("pend en", 16'h000c, pending[0])
      `CHK("fwd en", 16'h0008, fwd_req[0])
      apb(1'b0, 8'h20, 32'h0);
      `CHK("en rd", 32'h0000_0008, rdat)
   endtask
   task s_race;
      @(posedge clk);
      go[0][13] <= 1'b1;
      apb(1'b1, 8'h00, 32'h0);
      @(negedge clk);
      `CHK("set wins", 1'b1, pending[0][13])
      @(posedge clk);
      go <= '0;
      apb(1'b1, 8'h00, 32'h0);
      @(negedge clk);
      `CHK("clear", 16'h0000, pending[0])
      apb(1'b1, 8'h80, 32'hffff_ffff);
      `CHK("bad wr", 1'b1, rerr)
      apb(1'b0, 8'h80, 32'h0);
      `CHK("bad rd", 33'h0_0000_0001, {rdat, rerr})
   endtask
   task s_mid_reset;
      apb(1'b1, 8'h00, 32'h0000_ffff);
      @(negedge clk);
      `CHK("irq pre rst", 1'b1, irq)
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      `CHK("pend mid rst", '0, pending)
      `CHK("fwd mid rst", '0, fwd_req)
      `CHK("irq mid rst", 1'b0, irq)
      apb(1'b0, 8'h20, 32'h0);
      `CHK("en mid rst", 32'h0000_0000, rdat)
   endtask
   ////////////////////////////////////////////////////////////////////
   // Clock and main sequence
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      go = '0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      s_reset();
      s_rw();
      s_src();
      s_irq();
      s_enable();
      s_race();
      s_mid_reset();
      give_verdict();
   end
endmodule
